/* File: core/io_exchange_pkg.sv */
// Package for the periodic I/O data exchange block.
// Assumes a single 100 MHz system clock shared by every user.
package io_exchange_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int INTERVAL_MIN_US10 = 2;     // 0.2 ms in units of 0.1 ms
  localparam int INTERVAL_MAX_US10 = 7500;  // 750 ms in units of 0.1 ms
  localparam int CYCLES_PER_US10 = CLK_HZ / 10_000;
  localparam int INTERVAL_W = 27;
  localparam logic [INTERVAL_W-1:0] INTERVAL_MIN_CYC =
    INTERVAL_W'(INTERVAL_MIN_US10 * CYCLES_PER_US10);
  localparam logic [INTERVAL_W-1:0] INTERVAL_MAX_CYC =
    INTERVAL_W'(INTERVAL_MAX_US10 * CYCLES_PER_US10);
  localparam logic [INTERVAL_W-1:0] INTERVAL_RST_CYC = INTERVAL_MIN_CYC;

  // ****************************************
  // Packet layout
  // ****************************************
  localparam int CHANNELS = 16;

  typedef enum logic [1:0] {
    KIND_INPUT = 2'h0,
    KIND_ECHO = 2'h1,
    KIND_STATUS = 2'h2
  } pkt_kind_e;

  typedef struct packed {
    pkt_kind_e kind;
    logic [CHANNELS-1:0] data;
    logic [CHANNELS-1:0] quality;
    logic short_fault;
    logic event_flag;
  } io_packet_s;

  localparam int PKT_W = $bits(io_packet_s);

endpackage

/* File: core/io_exchange.sv */
// Periodic I/O exchange: input scan, output apply/echo/status, adapter relay.
// Assumes inputs are synchronous to clk_sys_i and the uplink drains a buffer.
`timescale 1ns/1ps

// Operation
// [R1] Input packets sent unpolled at each interval
// [R2] Sample channels first, then transmit
// [R3] Input packet carries values and status
// [R4] Events on change, done bit, pattern
// [R5] Controller sends at interval or immediate
// [R6] Immediate output restarts controller interval timer
// [R7] Remote immediate output refreshes every module
// [R8] Controller sends independent of program scan
// [R9] Drive outputs per stored configuration
// [R10] Echo after commanded value reaches terminals
// [R11] Echo shows observed terminal value
// [R12] Status each interval includes short flag
// [R13] Status carries per-channel quality each interval
// [R14] Adapter forwards backplane packets to network
// [R15] Adapter relays network output to backplane
// [R16] Interval limited to 0.2 to 750 ms
// [R17] Interval change only through reopen
// [R18] Timer counts, strobes once, reloads
module io_exchange
  import io_exchange_pkg::*;
#(
  parameter int N = CHANNELS
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Connection control
  input wire logic conn_open_i,
  input wire logic [INTERVAL_W-1:0] packet_interval_i,
  // Field side of input channels
  input wire logic [N-1:0] field_in_i,
  input wire logic done_bit_i,
  input wire logic [N-1:0] pattern_mask_i,
  input wire logic [N-1:0] pattern_value_i,
  // Output configuration and field terminal block
  input wire logic [N-1:0] invert_cfg_i,
  input wire logic [N-1:0] field_terminal_block_i,
  input wire logic [N-1:0] short_i,
  input wire logic [N-1:0] chan_ok_i,
  // Output data from controller via network adapter
  input wire logic out_valid_i,
  input wire logic [N-1:0] out_data_i,
  output logic out_ready_o,
  // Data toward controller via network adapter
  output logic up_valid_o,
  output io_packet_s up_pkt_o,
  input wire logic up_ready_i,
  // Local output drivers and event
  output logic [N-1:0] out_drive_o,
  output logic event_o,
  output logic conn_running_o
);

  // ****************************************
  // Connection and interval
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_REOPEN = 3'b100
  } conn_state_e;

  conn_state_e state;
  logic [INTERVAL_W-1:0] interval;
  logic [INTERVAL_W-1:0] tick_cnt;
  logic tick;

  function automatic logic [INTERVAL_W-1:0] clamp_interval(input logic [INTERVAL_W-1:0] v);
    if (v < INTERVAL_MIN_CYC) begin
      return INTERVAL_MIN_CYC;
    end else if (v > INTERVAL_MAX_CYC) begin
      return INTERVAL_MAX_CYC;
    end else begin
      return v;
    end
  endfunction

  // Interval latched only on open; a changed request forces a close first
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      interval <= INTERVAL_RST_CYC;
    end else begin
      case (state)
        ST_IDLE: begin
          if (conn_open_i) begin
            interval <= clamp_interval(packet_interval_i); // [R16]
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!conn_open_i) begin
            state <= ST_IDLE;
          end else if (clamp_interval(packet_interval_i) != interval) begin
            state <= ST_REOPEN; // [R17]
          end
        end
        ST_REOPEN: begin
          state <= ST_IDLE; // [R17]
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign conn_running_o = (state == ST_RUN);

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || state != ST_RUN) begin
      tick_cnt <= '0;
    end else if (tick_cnt >= interval - INTERVAL_W'(1)) begin
      tick_cnt <= '0; // [R18]
    end else begin
      tick_cnt <= tick_cnt + INTERVAL_W'(1);
    end
  end

  // One-cycle strobe, no poll involved
  assign tick = conn_running_o && (tick_cnt >= interval - INTERVAL_W'(1)); // [R1] [R18]

  // ****************************************
  // Input sampling and events
  // ****************************************
  logic [N-1:0] sample;
  logic [N-1:0] prev_in;
  logic prev_done;
  logic pattern_hit;
  logic prev_hit;
  logic evt_pending;
  logic send_input;
  logic pend_ready;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sample <= '0;
      send_input <= 1'b0;
    end else begin
      send_input <= tick;
      if (tick) begin
        sample <= field_in_i; // [R2]
      end
    end
  end

  assign pattern_hit = ((field_in_i & pattern_mask_i) == (pattern_value_i & pattern_mask_i))
                       && (pattern_mask_i != '0);

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      prev_in <= '0;
      prev_done <= 1'b0;
      prev_hit <= 1'b0;
      event_o <= 1'b0;
    end else begin
      prev_in <= field_in_i;
      prev_done <= done_bit_i;
      prev_hit <= pattern_hit;
      event_o <= conn_running_o && ((field_in_i != prev_in) || (done_bit_i != prev_done)
                 || (pattern_hit && !prev_hit)); // [R4]
    end
  end

  // Event flag rides the next input packet; a new event wins over the clear
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      evt_pending <= 1'b0;
    end else if (event_o) begin
      evt_pending <= 1'b1;
    end else if (send_input && pend_ready) begin
      evt_pending <= 1'b0;
    end
  end

  // ****************************************
  // Output apply and echo
  // ****************************************
  logic [N-1:0] commanded;
  logic echo_wait;
  logic send_echo;

  assign out_ready_o = 1'b1; // [R15]

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      out_drive_o <= '0;
      commanded <= '0;
    end else if (out_valid_i && conn_running_o) begin
      out_drive_o <= out_data_i ^ invert_cfg_i; // [R9]
      commanded <= out_data_i ^ invert_cfg_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || !conn_running_o) begin
      echo_wait <= 1'b0;
    end else if (out_valid_i) begin
      echo_wait <= 1'b1;
    end else if (send_echo && !send_input && pend_ready) begin
      // Held until the echo really wins a buffer slot
      echo_wait <= 1'b0;
    end
  end

  // Shorted channels never settle, so only healthy ones gate the echo
  assign send_echo = echo_wait
                     && (((field_terminal_block_i ^ commanded) & ~short_i) == '0); // [R10]

  // ****************************************
  // Packet arbitration and two-entry buffer
  // ****************************************
  localparam int DEPTH = 2;
  io_packet_s fifo_mem [DEPTH];
  logic [0:0] wr_ptr;
  logic [0:0] rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;
  logic status_due;
  io_packet_s next_pkt;

  assign pend_ready = (count != 2'(DEPTH));
  assign pop = up_valid_o && up_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || !conn_running_o) begin
      status_due <= 1'b0;
    end else if (tick) begin
      status_due <= 1'b1; // [R12]
    end else if (!send_input && !send_echo && pend_ready) begin
      status_due <= 1'b0;
    end
  end

  always_comb begin
    next_pkt = '0;
    push = 1'b0;
    if (send_input) begin
      next_pkt.kind = KIND_INPUT;
      next_pkt.data = sample; // [R3]
      next_pkt.quality = chan_ok_i;
      next_pkt.short_fault = |short_i;
      next_pkt.event_flag = evt_pending || event_o;
      push = pend_ready;
    end else if (send_echo) begin
      next_pkt.kind = KIND_ECHO;
      next_pkt.data = field_terminal_block_i; // [R11]
      next_pkt.quality = chan_ok_i;
      push = pend_ready;
    end else if (status_due) begin
      next_pkt.kind = KIND_STATUS;
      next_pkt.data = short_i;
      next_pkt.quality = chan_ok_i; // [R13]
      next_pkt.short_fault = |short_i; // [R12]
      push = pend_ready;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      fifo_mem[wr_ptr] <= next_pkt; // [R14]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + 2'(push) - 2'(pop);
    end
  end

  assign up_valid_o = (count != '0);
  assign up_pkt_o = up_valid_o ? fifo_mem[rd_ptr] : '0;

endmodule

/* File: sim/io_exchange_checker.sv */
// Checker: port timing relations of io_exchange.
// Assumes one clock domain; bound to every io_exchange instance.
`timescale 1ns/1ps
module io_exchange_checker
  import io_exchange_pkg::*;
#(
  parameter int N = CHANNELS
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Observed ports
  input wire logic conn_open_i,
  input wire logic [N-1:0] field_in_i,
  input wire logic done_bit_i,
  input wire logic [N-1:0] invert_cfg_i,
  input wire logic out_valid_i,
  input wire logic [N-1:0] out_data_i,
  input wire logic out_ready_o,
  input wire logic up_valid_o,
  input wire io_packet_s up_pkt_o,
  input wire logic up_ready_i,
  input wire logic [N-1:0] out_drive_o,
  input wire logic event_o,
  input wire logic conn_running_o
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // Saturates so a long run cannot wrap
  int unsigned run_cnt;
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || !conn_running_o) begin
      run_cnt <= 0;
    end else if (run_cnt < 30000) begin
      run_cnt <= run_cnt + 1;
    end
  end
  sequence take_s;
    conn_running_o && out_valid_i;
  endsequence
  ready_high_a: assert property (out_ready_o) else $error("out_ready low");
  idle_zero_a: assert property (!up_valid_o |-> up_pkt_o == '0)
    else $error("packet not zero when idle");
  drive_apply_a: assert property (take_s |=> out_drive_o == $past(out_data_i ^ invert_cfg_i))
    else $error("drive not data xor config");
  close_stop_a: assert property (!conn_open_i |=> !conn_running_o)
    else $error("running while closed");
  open_start_a: assert property ($rose(conn_running_o) |-> $past(conn_open_i))
    else $error("run without open");
  input_event_a: assert property (conn_running_o && $changed(field_in_i) |-> ##[0:2] event_o)
    else $error("no event on input change");
  done_event_a: assert property (conn_running_o && $changed(done_bit_i) |-> ##[0:2] event_o)
    else $error("no event on done bit change");
  uplink_hold_a: assert property (up_valid_o && !up_ready_i |=> up_valid_o && $stable(up_pkt_o))
    else $error("uplink packet dropped under stall");
  kind_legal_a: assert property (up_valid_o |-> up_pkt_o.kind != 2'h3)
    else $error("illegal packet kind");
  first_tick_a: assert property (up_valid_o && up_pkt_o.kind == KIND_INPUT |->
    run_cnt >= INTERVAL_MIN_CYC) else $error("input packet before interval");
endmodule
bind io_exchange io_exchange_checker #(.N(N)) i_io_exchange_checker (.clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i), .conn_open_i(conn_open_i), .field_in_i(field_in_i),
  .done_bit_i(done_bit_i), .invert_cfg_i(invert_cfg_i), .out_valid_i(out_valid_i),
  .out_data_i(out_data_i), .out_ready_o(out_ready_o), .up_valid_o(up_valid_o),
  .up_pkt_o(up_pkt_o), .up_ready_i(up_ready_i), .out_drive_o(out_drive_o),
  .event_o(event_o), .conn_running_o(conn_running_o));

/* File: sim/controller_model.sv */
// Controller model: sends output words at its interval or on demand.
// Assumes the bench pulses imm_i for one cycle while running.
`timescale 1ns/1ps
module controller_model #(
  parameter int N = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Control
  input wire logic run_i,
  input wire logic imm_i,
  input wire logic [31:0] ivl_i,
  // Module side
  input wire logic out_ready_i,
  output logic out_valid_o,
  output logic [N-1:0] out_data_o,
  output logic up_ready_o
);
  int cnt;
  logic fire;
  // Own timer runs at the connection interval, scan plays no part
  assign fire = imm_i || (cnt >= int'(ivl_i) - 1);
  always_ff @(posedge clk_sys_i) begin
    // Random stalls on the uplink
    up_ready_o <= ($urandom % 4) != 0;
    if (!reset_n_i || !run_i) begin
      cnt <= 0;
      out_valid_o <= 1'h0;
      out_data_o <= '0;
    end else if (out_valid_o && !out_ready_i) begin
      // Word held until taken
      cnt <= cnt + 1;
    end else begin
      // Data changes every cycle so idle words are never stale
      out_data_o <= N'($urandom);
      out_valid_o <= fire;
      cnt <= fire ? 0 : cnt + 1;
    end
  end
endmodule

/* File: sim/testbench.sv */
// Bench for io_exchange with a controller model and field loopback.
// Assumes the package clamp limits and a 100 MHz clock.
`timescale 1ns/1ps
module testbench;
  import io_exchange_pkg::*;
  logic clk_sys_i = 0, reset_n_i = 0, conn_open_i = 0, done_bit_i = 0, imm = 0;
  logic [INTERVAL_W-1:0] packet_interval_i = 5;
  logic [CHANNELS-1:0] field_in_i = 0, pattern_mask_i, pattern_value_i, invert_cfg_i;
  logic [CHANNELS-1:0] field_terminal_block_i = 0, short_i, chan_ok_i;
  logic out_valid_i, out_ready_o, up_valid_o, up_ready_i, event_o, conn_running_o, chk = 0;
  logic evt_exp = 0;
  logic [31:0] ctl_ivl;
  logic [CHANNELS-1:0] out_data_i, out_drive_o, exp_drive = 0;
  io_packet_s up_pkt_o;
  int fail_count = 0, n_tests = 0, n_in = 0, n_st = 0, n_echo = 0, m;
  longint cyc = 0, last_in = 0, d;
  io_exchange i_io_exchange (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .conn_open_i(conn_open_i), .packet_interval_i(packet_interval_i), .field_in_i(field_in_i),
    .done_bit_i(done_bit_i), .pattern_mask_i(pattern_mask_i), .pattern_value_i(pattern_value_i),
    .invert_cfg_i(invert_cfg_i), .field_terminal_block_i(field_terminal_block_i),
    .short_i(short_i), .chan_ok_i(chan_ok_i), .out_valid_i(out_valid_i),
    .out_data_i(out_data_i), .out_ready_o(out_ready_o), .up_valid_o(up_valid_o),
    .up_pkt_o(up_pkt_o), .up_ready_i(up_ready_i), .out_drive_o(out_drive_o),
    .event_o(event_o), .conn_running_o(conn_running_o));
  controller_model #(.N(CHANNELS)) i_controller_model (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .run_i(conn_running_o), .imm_i(imm), .ivl_i(ctl_ivl),
    .out_ready_i(out_ready_o),
    .out_valid_o(out_valid_i), .out_data_o(out_data_i), .up_ready_o(up_ready_i));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic longint exp_ivl(input logic [INTERVAL_W-1:0] v);
    if (v < INTERVAL_MIN_CYC) return INTERVAL_MIN_CYC;
    if (v > INTERVAL_MAX_CYC) return INTERVAL_MAX_CYC;
    return v;
  endfunction
  assign ctl_ivl = 32'(exp_ivl(packet_interval_i));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (exp !== got) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial forever #5 clk_sys_i = ~clk_sys_i;
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    fail_count++;
    print_verdict();
  end
  // Terminals follow the drive, a shorted channel reads inverted
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    chk <= out_valid_i && conn_running_o;
    exp_drive <= out_data_i ^ invert_cfg_i;
    field_terminal_block_i <= out_drive_o ^ short_i;
  end
  // Checks settle at the falling edge
  always @(negedge clk_sys_i) if (reset_n_i) begin
    if (chk) check("out_drive", exp_drive, out_drive_o);
    if (up_valid_o && up_ready_i) begin
      if (up_pkt_o.kind === KIND_INPUT) begin
        d = cyc - last_in;
        check("input data", field_in_i, up_pkt_o.data);
        check("event flag", evt_exp, up_pkt_o.event_flag);
        evt_exp = 0;
        check("interval", 1, d + 6 >= exp_ivl(packet_interval_i) &&
          d <= exp_ivl(packet_interval_i) + 6);
        last_in = cyc;
        n_in++;
      end else if (up_pkt_o.kind === KIND_ECHO) begin
        check("echo data", field_terminal_block_i, up_pkt_o.data);
        n_echo++;
      end else begin
        check("short flag", |short_i, up_pkt_o.short_fault);
        check("quality", chan_ok_i, up_pkt_o.quality);
        n_st++;
      end
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(18));
    invert_cfg_i <= $urandom;
    short_i <= 16'h0001;
    chan_ok_i <= $urandom;
    pattern_mask_i <= 16'h0003;
    pattern_value_i <= 16'h0001;
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1;
    @(negedge clk_sys_i);
    check("ready", 1, out_ready_o);
    check("valid", 0, up_valid_o);
    @(posedge clk_sys_i);
    conn_open_i <= 1;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("running", 1, conn_running_o);
    last_in = cyc;
    for (int k = 0; k < 3; k++) begin
      m = n_in;
      repeat (30000) if (n_in == m) @(posedge clk_sys_i);
      check("input sent", 1, n_in > m);
      repeat (100) @(posedge clk_sys_i);
      field_in_i <= $urandom;
      done_bit_i <= ~done_bit_i;
      evt_exp = 1;
      imm <= k == 0;
      if (k == 1) begin
        packet_interval_i <= 25000;
        short_i <= 0;
        chan_ok_i <= $urandom;
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check("reopen drop", 0, conn_running_o);
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check("reopened", 1, conn_running_o);
        // Run resumed six edges back; same base as the first open
        last_in = cyc - 6;
      end
      @(posedge clk_sys_i);
      imm <= 0;
    end
    check("status seen", 1, n_st > 0);
    check("echo seen", 1, n_echo > 0);
    print_verdict();
  end
endmodule
